/* File: verilog/itm_pkg.sv */
// package of constants for the 16-bit interval timer
// assumes a single 40 MHz system clock and a plain strobe register port
//
// Notes on behaviour
// - hidden 16-bit up-counter on selected count clock
// - three-bit select picks one of eight clocks
// - enable low holds clock, resets counter
// - enable starts at FFFF, wraps to zero
// - match clears counter and raises interrupt
// - interval is compare plus one counts
// - compare zero interrupts every count clock
// - compare N counts to N then clears
// - compare register 16 bits, resets zero
// - control register 8 bits, resets zero
// - counting starts within clock-dependent delay
// - tick source starts by second tick edge
// - clear-and-restart only, no free-run
package itm_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0] ITM_ADDR_CTL = 4'h0;
    localparam logic [3:0] ITM_ADDR_CMP = 4'h4;
    localparam logic [3:0] ITM_ADDR_STS = 4'h8;
    localparam logic [3:0] ITM_ADDR_MSK = 4'hc;
    localparam logic [7:0] ITM_CTL_RST = 8'h00;
    localparam logic [15:0] ITM_CMP_RST = 16'h0000;
    localparam logic [15:0] ITM_CNT_IDLE = 16'hffff;
    localparam logic [15:0] ITM_CNT_ZERO = 16'h0000;
    localparam int ITM_CTL_EN_BIT = 7;
    localparam int ITM_CTL_SEL_LSB = 0;
    localparam logic [7:0] ITM_CTL_WMASK = 8'h87;
    // ************************************************************
    // clock select codes
    // ************************************************************
    typedef enum logic [2:0] {
        ITM_SEL_DIV1 = 3'b000,
        ITM_SEL_DIV2 = 3'b001,
        ITM_SEL_DIV4 = 3'b010,
        ITM_SEL_DIV64 = 3'b011,
        ITM_SEL_DIV512 = 3'b100,
        ITM_SEL_TICK = 3'b101,
        ITM_SEL_LOSC8 = 3'b110,
        ITM_SEL_SUB = 3'b111
    } itm_sel_t;
    localparam int ITM_PRE_W = 9;
    localparam int ITM_LOSC_DIV = 8;
    // ************************************************************
    // longest wait before the first count, in system clocks
    // ************************************************************
    localparam int ITM_START_DIV1 = 2;
    localparam int ITM_START_DIV2 = 3;
    localparam int ITM_START_DIV4 = 6;
    localparam int ITM_START_DIV64 = 128;
    localparam int ITM_START_DIV512 = 1024;
    localparam int ITM_START_NONE = 4096;
endpackage

/* File: verilog/itm_edge.sv */
// rising-edge detector for slow source clocks sampled by clk_i
// assumes the source level is synchronous to clk_i
module itm_edge (
    input wire logic clk_i, // system clock
    input wire logic srst_i, // sync reset
    input wire logic lvl_i, // slow level
    output logic rise_o // one-cycle rise pulse
);
    logic lvl_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i) lvl_reg <= 1'b0;
        else lvl_reg <= lvl_i;
    end
    assign rise_o = lvl_i & ~lvl_reg;
endmodule // itm_edge

/* File: verilog/itm_cksel.sv */
// count-clock enable generator: prescaler and source select
// assumes all inputs synchronous to clk_i
module itm_cksel
    import itm_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic srst_i, // sync reset
    input wire logic run_i, // run enable
    input wire logic [2:0] sel_i, // clock select
    input wire logic tick_i, // watch tick level
    input wire logic losc_i, // low-speed osc level
    input wire logic sub_i, // subclock level
    output logic cnt_en_o // count pulse
);
    logic [ITM_PRE_W-1:0] pre_reg;
    logic [2:0] losc_cnt_reg;
    logic tick_rise;
    logic losc_rise;
    logic sub_rise;
    logic losc8;
    itm_edge u_tick (.clk_i(clk_i), .srst_i(srst_i), .lvl_i(tick_i), .rise_o(tick_rise));
    itm_edge u_losc (.clk_i(clk_i), .srst_i(srst_i), .lvl_i(losc_i), .rise_o(losc_rise));
    itm_edge u_sub (.clk_i(clk_i), .srst_i(srst_i), .lvl_i(sub_i), .rise_o(sub_rise));
    // prescaler cleared while stopped
    always_ff @(posedge clk_i) begin
        if (srst_i || !run_i) pre_reg <= '0;
        else pre_reg <= pre_reg + 1'b1;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i || !run_i) losc_cnt_reg <= '0;
        else if (losc_rise) losc_cnt_reg <= losc_cnt_reg + 1'b1;
    end
    assign losc8 = losc_rise && (losc_cnt_reg == 3'(ITM_LOSC_DIV - 1));
    always_comb begin
        case (itm_sel_t'(sel_i))
            ITM_SEL_DIV1: cnt_en_o = run_i;
            ITM_SEL_DIV2: cnt_en_o = run_i && (pre_reg[0] == 1'b1);
            ITM_SEL_DIV4: cnt_en_o = run_i && (pre_reg[1:0] == 2'h3);
            ITM_SEL_DIV64: cnt_en_o = run_i && (pre_reg[5:0] == 6'h3f);
            ITM_SEL_DIV512: cnt_en_o = run_i && (pre_reg == 9'h1ff);
            ITM_SEL_TICK: cnt_en_o = run_i && tick_rise;
            ITM_SEL_LOSC8: cnt_en_o = run_i && losc8;
            ITM_SEL_SUB: cnt_en_o = run_i && sub_rise;
            default: cnt_en_o = 1'b0;
        endcase
    end
endmodule // itm_cksel

/* File: verilog/itm_timer.sv */
// 16-bit interval timer top: registers, counter, interrupt
// assumes a plain strobe register port, read data one cycle later
//
// The plain strobed port and the address map were left to the implementer.
module itm_timer
    import itm_pkg::*;
(
    input wire logic clk_i, // 40 MHz system clock
    input wire logic srst_i, // sync reset, active high
    input wire logic [3:0] addr_i, // register byte address
    input wire logic [15:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [15:0] rdata_o, // read data, cycle after rd_i
    input wire logic watch_timer_tick_i, // watch-timer tick level
    input wire logic low_speed_osc_clock_i, // low-speed osc level
    input wire logic sub_clock_i, // subclock level
    output logic compare_match_irq_o, // match pulse
    output logic irq_o // level interrupt
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] ctl_reg;
    logic [15:0] cmp_reg;
    logic [15:0] cnt_reg;
    logic sts_reg;
    logic msk_reg;
    logic irq_pulse_reg;
    logic [15:0] rdata_reg;
    logic run_enable_bit;
    logic [2:0] sel;
    logic cnt_en;
    logic match;
    logic wr_ctl;
    logic wr_cmp;
    logic wr_sts;
    logic wr_msk;
    logic [15:0] rd_mux;
    logic [15:0] cnt_next;

    assign run_enable_bit = ctl_reg[ITM_CTL_EN_BIT];
    assign sel = ctl_reg[ITM_CTL_SEL_LSB +: 3];
    assign wr_ctl = wr_i && (addr_i == ITM_ADDR_CTL);
    assign wr_cmp = wr_i && (addr_i == ITM_ADDR_CMP);
    assign wr_sts = wr_i && (addr_i == ITM_ADDR_STS);
    assign wr_msk = wr_i && (addr_i == ITM_ADDR_MSK);

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) ctl_reg <= ITM_CTL_RST;
        else if (wr_ctl) ctl_reg <= wdata_i[7:0] & ITM_CTL_WMASK;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) cmp_reg <= ITM_CMP_RST;
        else if (wr_cmp) cmp_reg <= wdata_i;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) msk_reg <= 1'b0;
        else if (wr_msk) msk_reg <= wdata_i[0];
    end

    // ************************************************************
    // count clock and counter
    // ************************************************************
    itm_cksel u_cksel (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .run_i(run_enable_bit),
        .sel_i(sel),
        .tick_i(watch_timer_tick_i),
        .losc_i(low_speed_osc_clock_i),
        .sub_i(sub_clock_i),
        .cnt_en_o(cnt_en)
    );

    // counter never visible to software
    assign match = cnt_en && (cnt_reg == cmp_reg);
    // idle FFFF wraps to 0 on first count; match clears, no free-run
    assign cnt_next = (match || cnt_reg == ITM_CNT_IDLE) ? ITM_CNT_ZERO
                                                        : cnt_reg + 16'h0001;
    always_ff @(posedge clk_i) begin
        if (srst_i || !run_enable_bit) cnt_reg <= ITM_CNT_IDLE;
        else if (cnt_en) cnt_reg <= cnt_next;
    end

    // ************************************************************
    // interrupt
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) irq_pulse_reg <= 1'b0;
        else irq_pulse_reg <= match;
    end
    assign compare_match_irq_o = irq_pulse_reg;
    // set wins over write-one-clear
    always_ff @(posedge clk_i) begin
        if (srst_i) sts_reg <= 1'b0;
        else if (match) sts_reg <= 1'b1;
        else if (wr_sts && wdata_i[0]) sts_reg <= 1'b0;
    end
    assign irq_o = sts_reg & msk_reg;

    // ************************************************************
    // read port
    // ************************************************************
    assign rd_mux = (addr_i == ITM_ADDR_CTL) ? {8'h00, ctl_reg} :
                    (addr_i == ITM_ADDR_CMP) ? cmp_reg :
                    (addr_i == ITM_ADDR_STS) ? {15'h0000, sts_reg} :
                    (addr_i == ITM_ADDR_MSK) ? {15'h0000, msk_reg} : 16'h0000;
    always_ff @(posedge clk_i) begin
        if (srst_i) rdata_reg <= 16'h0000;
        else if (rd_i) rdata_reg <= rd_mux;
        else rdata_reg <= 16'h0000;
    end
    assign rdata_o = rdata_reg;

    // ************************************************************
    // checks
    // ************************************************************
    // start-delay watch: cycles since enable without a count pulse
    logic started_reg;
    logic [10:0] wait_reg;
    function automatic int start_limit(input logic [2:0] s);
        case (itm_sel_t'(s))
            ITM_SEL_DIV1: start_limit = ITM_START_DIV1;
            ITM_SEL_DIV2: start_limit = ITM_START_DIV2;
            ITM_SEL_DIV4: start_limit = ITM_START_DIV4;
            ITM_SEL_DIV64: start_limit = ITM_START_DIV64;
            ITM_SEL_DIV512: start_limit = ITM_START_DIV512;
            default: start_limit = ITM_START_NONE;
        endcase
    endfunction
    always_ff @(posedge clk_i) begin
        if (srst_i || !run_enable_bit) started_reg <= 1'b0;
        else if (cnt_en) started_reg <= 1'b1;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i || !run_enable_bit) wait_reg <= 11'h000;
        else if (!started_reg && wait_reg != 11'h7ff) wait_reg <= wait_reg + 11'h001;
    end
    start_delay_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (run_enable_bit && !started_reg && !cnt_en) |-> int'(wait_reg) + 2 <= start_limit(sel))
        else $error("count start too late");
    match_clears_a: assert property (@(posedge clk_i) disable iff (srst_i)
        match |=> cnt_reg == ITM_CNT_ZERO && compare_match_irq_o)
        else $error("match did not clear counter");
    stop_resets_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !run_enable_bit |=> (cnt_reg == ITM_CNT_IDLE || run_enable_bit))
        else $error("counter not held while stopped");
    zero_every_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cnt_en && cmp_reg == 16'h0000 && cnt_reg == 16'h0000) |=> compare_match_irq_o)
        else $error("zero compare missed interrupt");
    start_wrap_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cnt_en && cnt_reg == ITM_CNT_IDLE) |=> cnt_reg == ITM_CNT_ZERO)
        else $error("start did not wrap to zero");
    count_up_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cnt_en && !match && cnt_reg != ITM_CNT_IDLE) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter failed to increment");
    no_count_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (!cnt_en && run_enable_bit && $past(run_enable_bit)) |=> $stable(cnt_reg))
        else $error("counter moved without count clock");
    div1_start_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ($rose(run_enable_bit) && sel == ITM_SEL_DIV1) |-> cnt_en)
        else $error("main clock start too late");
    irq_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i)
        compare_match_irq_o |-> $past(match))
        else $error("interrupt pulse without match");
    irq_level_a: assert property (@(posedge clk_i) disable iff (srst_i)
        compare_match_irq_o |-> sts_reg)
        else $error("status not set on match");
    match_cv: cover property (@(posedge clk_i) disable iff (srst_i) compare_match_irq_o);
    zero_cv: cover property (@(posedge clk_i) disable iff (srst_i)
        match && cmp_reg == 16'h0000);
    irq_cv: cover property (@(posedge clk_i) disable iff (srst_i) irq_o);
endmodule // itm_timer

/* File: sim/itm_timer_tb.sv */
// self-checking bench for the 16-bit interval timer
// assumes itm_pkg and itm_timer are compiled before it
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module itm_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import itm_pkg::*;
    // ************************************************************
    // stimulus, sources and design
    // ************************************************************
    logic clk_i, srst_i, wr_i, rd_i, tick, losc, sub, cmi_o, irq_o;
    logic [3:0] addr_i;
    logic [15:0] wdata_i, rdata_o, v;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    // compare value and count clock period per select code
    function automatic logic [15:0] cmp_of(input int i);
        case (i)
            0: cmp_of = 16'h0003;
            2, 5: cmp_of = 16'h0002;
            3, 4, 6: cmp_of = 16'h0001;
            default: cmp_of = 16'h0000;
        endcase
    endfunction
    function automatic int div_of(input int i);
        case (i)
            0: div_of = 1;
            1: div_of = 2;
            2: div_of = 4;
            3: div_of = 64;
            4: div_of = 512;
            5: div_of = 10;
            6: div_of = 32;
            default: div_of = 6;
        endcase
    endfunction
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // slow sources: tick period 10, losc period 4, sub period 6
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        tick <= (cyc % 10) < 5;
        losc <= (cyc % 4) < 2;
        sub <= (cyc % 6) < 3;
    end
    itm_timer i_itm_timer (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .watch_timer_tick_i(tick), .low_speed_osc_clock_i(losc), .sub_clock_i(sub),
        .compare_match_irq_o(cmi_o), .irq_o(irq_o));
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // cycles from one match pulse to the next
    task automatic gap(output int c);
        c = 0;
        while (cmi_o !== 1'b1 && c < 3000) begin
            @(posedge clk_i);
            #1 c++;
        end
        c = 0;
        do begin
            @(posedge clk_i);
            #1 c++;
        end while (cmi_o !== 1'b1 && c < 3000);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        srst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(ITM_ADDR_CTL, v);
        `CHK("ctl reset", 16'h0000, v)
        rd(ITM_ADDR_CMP, v);
        `CHK("cmp reset", 16'h0000, v)
        wr(ITM_ADDR_CMP, 16'hfffe);
        rd(ITM_ADDR_CMP, v);
        `CHK("cmp write", 16'hfffe, v)
        wr(4'h2, 16'hffff);
        rd(4'h2, v);
        `CHK("unmapped", 16'h0000, v)
        wr(ITM_ADDR_CTL, 16'h0007);
        wr(ITM_ADDR_CTL, 16'h0087);
        rd(ITM_ADDR_CTL, v);
        `CHK("ctl write", 16'h0087, v)
        wr(ITM_ADDR_CTL, 16'h0007);
        wr(ITM_ADDR_CTL, 16'h0007);
        rd(ITM_ADDR_CTL, v);
        `CHK("ctl same value", 16'h0007, v)
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            wr(ITM_ADDR_CTL, {13'h0000, i[2:0]});
            wr(ITM_ADDR_CMP, cmp_of(i));
            wr(ITM_ADDR_CTL, {8'h00, 5'h10, i[2:0]});
            gap(n);
            `CHK("interval", (int'(cmp_of(i)) + 1) * div_of(i), n)
            wr(ITM_ADDR_CTL, {13'h0000, i[2:0]});
        end
        $display("test intervals done");
        wr(ITM_ADDR_CTL, 16'h0000);
        wr(ITM_ADDR_CMP, 16'h0003);
        wr(ITM_ADDR_CTL, 16'h0080);
        n = 0;
        while (cmi_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            #1 n++;
        end
        `CHK("first match", 1'b1, n >= 4 && n <= 7)
        wr(ITM_ADDR_CTL, 16'h0000);
        n = 0;
        repeat (60) begin
            @(posedge clk_i);
            #1 n += int'(cmi_o === 1'b1);
        end
        `CHK("stopped", 0, n)
        $display("test start and stop done");
        rd(ITM_ADDR_STS, v);
        `CHK("status set", 16'h0001, v)
        `CHK("masked", 1'b0, irq_o)
        wr(ITM_ADDR_MSK, 16'h0001);
        @(posedge clk_i);
        #1 `CHK("unmasked", 1'b1, irq_o)
        wr(ITM_ADDR_STS, 16'h0001);
        @(posedge clk_i);
        #1 `CHK("cleared", 1'b0, irq_o)
        rd(ITM_ADDR_STS, v);
        `CHK("status clear", 16'h0000, v)
        $display("test interrupt done");
        wr(ITM_ADDR_CTL, 16'h0080);
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(ITM_ADDR_CTL, v);
        `CHK("ctl mid reset", 16'h0000, v)
        rd(ITM_ADDR_CMP, v);
        `CHK("cmp mid reset", 16'h0000, v)
        n = 0;
        repeat (20) begin
            @(posedge clk_i);
            #1 n += int'(cmi_o === 1'b1);
        end
        `CHK("quiet after reset", 0, n)
        `CHK("irq after reset", 1'b0, irq_o)
        $display("test mid reset done");
        conclude();
    end
    initial begin
        #(25 * 40000);
        fails++;
        conclude();
    end
endmodule // itm_timer_tb
